// ### hw/store_route_pkg.sv
// Package: register map, field layouts, limits and timing for the store and done-route block
// Assumes a 32-bit APB slave and a 25 MHz clock
package store_route_pkg;
  // ------------------------------------------------------------
  // Register offsets (byte addresses)
  // ------------------------------------------------------------
  localparam logic [11:0] OFS_BASE = 12'h000;
  localparam logic [11:0] OFS_LENGTH = 12'h004;
  localparam logic [11:0] OFS_ENABLE = 12'h008;
  localparam logic [11:0] OFS_ROUTE = 12'h00C;
  localparam logic [11:0] OFS_TIMING = 12'h010;
  localparam logic [11:0] OFS_LIMIT_QUERY = 12'h014;
  localparam logic [11:0] OFS_LIMIT_DATA = 12'h018;
  localparam logic [11:0] OFS_STORE_PTR = 12'h01C;
  localparam logic [11:0] OFS_READING = 12'h020;
  localparam logic [11:0] OFS_IRQ_STATUS = 12'h024;
  localparam logic [11:0] OFS_IRQ_ENABLE = 12'h028;
  localparam logic [11:0] OFS_IRQ_CLEAR = 12'h02C;
  localparam logic [11:0] OFS_SAMPLE = 12'h030;
  // ------------------------------------------------------------
  // Limits and reset values
  // ------------------------------------------------------------
  localparam logic [23:0] BASE_MIN = 24'h200000;
  localparam logic [23:0] BASE_MAX = 24'hDFFFFC;
  localparam logic [23:0] BASE_RESET = 24'h200000;
  localparam logic [23:0] LENGTH_MIN = 24'h000000;
  localparam logic [23:0] LENGTH_MAX = 24'hC00000;
  localparam logic [23:0] LENGTH_RESET = 24'h000000;
  localparam logic [24:0] REGION_TOP = 25'h0E00000;
  localparam logic [23:0] BYTES_PER_READING = 24'h000004;
  // Limit-query selector codes
  localparam logic [1:0] QSEL_PRESENT = 2'h0;
  localparam logic [1:0] QSEL_MIN = 2'h1;
  localparam logic [1:0] QSEL_MAX = 2'h2;
  localparam logic QOBJ_BASE = 1'b0;
  // Timing field: bit 0 autozero, bits 2:1 aperture code
  localparam int TIMING_AZ_BIT = 0;
  localparam int TIMING_AP_LSB = 1;
  localparam logic [1:0] AP_10US = 2'h0;
  localparam logic [1:0] AP_100US = 2'h1;
  // Done-low times in microseconds, and counts at 25 MHz
  localparam int CLK_MHZ = 25;
  localparam int DONE_US_10_AZOFF = 70;
  localparam int DONE_US_100_AZOFF = 250;
  localparam int DONE_US_100_AZON = 520;
  localparam logic [15:0] DONE_CYC_10_AZOFF = 16'(DONE_US_10_AZOFF * CLK_MHZ);
  localparam logic [15:0] DONE_CYC_100_AZOFF = 16'(DONE_US_100_AZOFF * CLK_MHZ);
  localparam logic [15:0] DONE_CYC_100_AZON = 16'(DONE_US_100_AZON * CLK_MHZ);
  // Interrupt status bits
  localparam int IRQ_DONE = 0;
  localparam int IRQ_STORED = 1;
  localparam int IRQ_FULL = 2;
  localparam int IRQ_BADCFG = 3;
  localparam int IRQ_W = 4;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_LOW = 3'b010,
    ST_STORE = 3'b100
  } done_state_e;

  // External memory write request
  typedef struct packed {
    logic valid;
    logic [23:0] addr;
    logic [31:0] data;
  } mem_req_s;
endpackage : store_route_pkg

// ### hw/store_route.sv
// Reading-store setup, done-pulse generation and backplane trigger routing
// Assumes APB master on REF_CLK, sync reset, memory card accepts one write per cycle
// ------------------------------------------------------------
// ------------------------------------------------------------
`timescale 1ns/1ns
module store_route #(
  parameter int LINES = 8
) (
  input wire logic REF_CLK,
  input wire logic RESET,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [11:0] PADDR,
  input wire logic [31:0] PWDATA,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  input wire logic SAMPLE_TAKEN,
  input wire logic [31:0] READING,
  input wire logic [LINES-1:0] TRIGGER_LINE_IN,
  output logic [LINES-1:0] TRIGGER_LINE_OE,
  output logic [LINES-1:0] TRIGGER_LINE_OUT,
  output logic MEASUREMENT_DONE_OUT_N,
  output logic MEM_WRITE,
  output logic [23:0] MEM_ADDR,
  output logic [31:0] MEM_DATA,
  output logic IRQ
);
  // ------------------------------------------------------------
  // State
  // ------------------------------------------------------------
  // Status width first, so the state struct below can size its fields
  localparam int IRQ_W_T = store_route_pkg::IRQ_W;
  typedef struct packed {
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic [23:0] ext_store_base;
    logic [23:0] ext_store_length;
    logic ext_store_enable;
    logic [LINES-1:0] done_line_route;
    logic [2:0] timing;
    logic [2:0] query_sel;
    logic [23:0] store_offset;
    logic [31:0] reading;
    logic [IRQ_W_T-1:0] irq_status;
    logic [IRQ_W_T-1:0] irq_enable;
    store_route_pkg::done_state_e state;
    logic [15:0] low_count;
    logic done_n;
    logic [LINES-1:0] line_oe;
    store_route_pkg::mem_req_s mem;
    logic irq;
    logic [1:0] sample_sync;
  } state_s;

  state_s cur;
  state_s next_cur;
  logic [LINES-1:0] trigger_sync1;
  logic [LINES-1:0] trigger_sync2;
  logic sample_sync1;

  // ------------------------------------------------------------
  // Input synchronisers
  // ------------------------------------------------------------
  // SAMPLE_TAKEN and the trigger lines pass two flip-flops; trigger lines are only read back for status
  always_ff @(posedge REF_CLK) begin
    sample_sync1 <= SAMPLE_TAKEN;
    trigger_sync1 <= TRIGGER_LINE_IN;
    trigger_sync2 <= trigger_sync1;
  end

  // ------------------------------------------------------------
  // Done-pulse timing
  // ------------------------------------------------------------
  // Done-low time from aperture code and autozero
  function automatic logic [15:0] low_time(input logic [2:0] t);
    logic [1:0] ap;
    ap = t[store_route_pkg::TIMING_AP_LSB +: 2];
    if (ap == store_route_pkg::AP_10US) begin
      low_time = store_route_pkg::DONE_CYC_10_AZOFF;
    end else if (t[store_route_pkg::TIMING_AZ_BIT]) begin
      low_time = store_route_pkg::DONE_CYC_100_AZON;
    end else begin
      low_time = store_route_pkg::DONE_CYC_100_AZOFF;
    end
  endfunction : low_time

  // ------------------------------------------------------------
  // Next-state logic
  // ------------------------------------------------------------
  // Main next-state logic
  always_comb begin
    logic access;
    logic wr;
    logic [23:0] wval;
    logic sample_edge;
    logic [IRQ_W_T-1:0] ev;
    logic [IRQ_W_T-1:0] clr;
    logic [24:0] span;
    access = 1'b0;
    wr = 1'b0;
    wval = 24'h000000;
    sample_edge = 1'b0;
    ev = '0;
    clr = '0;
    span = 25'h0000000;
    next_cur = cur;
    next_cur.pready = 1'b0;
    next_cur.pslverr = 1'b0;
    next_cur.mem.valid = 1'b0;
    next_cur.sample_sync = {cur.sample_sync[0], sample_sync1};
    sample_edge = cur.sample_sync[0] & ~cur.sample_sync[1];

    // APB: one wait state, answer in the cycle after the first access cycle
    access = PSEL && PENABLE && !cur.pready;
    wr = access && PWRITE;
    wval = PWDATA[23:0];
    if (access) begin
      next_cur.pready = 1'b1;
      next_cur.prdata = 32'h00000000;
      unique case (PADDR)
        store_route_pkg::OFS_BASE: begin
          next_cur.prdata = {8'h00, cur.ext_store_base};
          if (wr) begin
            // Out-of-range or misaligned base is refused
            if (wval < store_route_pkg::BASE_MIN || wval > store_route_pkg::BASE_MAX
                || wval[1:0] != 2'h0 || PWDATA[31:24] != 8'h00) begin
              next_cur.pslverr = 1'b1;
            end else begin
              next_cur.ext_store_base = wval;
            end
          end
        end
        store_route_pkg::OFS_LENGTH: begin
          next_cur.prdata = {8'h00, cur.ext_store_length};
          if (wr) begin
            // Binary word serves decimal and hex alike
            if (wval > store_route_pkg::LENGTH_MAX || PWDATA[31:24] != 8'h00) begin
              next_cur.pslverr = 1'b1;
            end else begin
              next_cur.ext_store_length = wval;
            end
          end
        end
        store_route_pkg::OFS_ENABLE: begin
          next_cur.prdata = {31'h00000000, cur.ext_store_enable};
          if (wr) begin
            next_cur.ext_store_enable = PWDATA[0];
            next_cur.store_offset = 24'h000000;
          end
        end
        store_route_pkg::OFS_ROUTE: begin
          next_cur.prdata = 32'(cur.done_line_route);
          if (wr) begin
            next_cur.done_line_route = PWDATA[LINES-1:0];
          end
        end
        store_route_pkg::OFS_TIMING: begin
          next_cur.prdata = {29'h00000000, cur.timing};
          if (wr) begin
            next_cur.timing = PWDATA[2:0];
          end
        end
        store_route_pkg::OFS_LIMIT_QUERY: begin
          next_cur.prdata = {29'h00000000, cur.query_sel};
          if (wr) begin
            next_cur.query_sel = PWDATA[2:0];
          end
        end
        store_route_pkg::OFS_LIMIT_DATA: begin
          // Bit 2 picks the object, bits 1:0 present/min/max
          if (cur.query_sel[2] == store_route_pkg::QOBJ_BASE) begin
            unique case (cur.query_sel[1:0])
              store_route_pkg::QSEL_MIN: next_cur.prdata = {8'h00, store_route_pkg::BASE_MIN};
              store_route_pkg::QSEL_MAX: next_cur.prdata = {8'h00, store_route_pkg::BASE_MAX};
              default: next_cur.prdata = {8'h00, cur.ext_store_base};
            endcase
          end else begin
            unique case (cur.query_sel[1:0])
              store_route_pkg::QSEL_MIN: next_cur.prdata = {8'h00, store_route_pkg::LENGTH_MIN};
              store_route_pkg::QSEL_MAX: next_cur.prdata = {8'h00, store_route_pkg::LENGTH_MAX};
              default: next_cur.prdata = {8'h00, cur.ext_store_length};
            endcase
          end
        end
        store_route_pkg::OFS_STORE_PTR: next_cur.prdata = {8'h00, cur.store_offset};
        store_route_pkg::OFS_READING: next_cur.prdata = cur.reading;
        store_route_pkg::OFS_IRQ_STATUS: next_cur.prdata = 32'(cur.irq_status);
        store_route_pkg::OFS_IRQ_ENABLE: begin
          next_cur.prdata = 32'(cur.irq_enable);
          if (wr) begin
            next_cur.irq_enable = PWDATA[IRQ_W_T-1:0];
          end
        end
        store_route_pkg::OFS_IRQ_CLEAR: begin
          if (wr) begin
            clr = PWDATA[IRQ_W_T-1:0];
          end
        end
        store_route_pkg::OFS_SAMPLE: begin
          next_cur.prdata = 32'(trigger_sync2);
        end
        default: next_cur.pslverr = 1'b1; // Unmapped address
      endcase
    end

    // Done pulse: low per reading, then store when enabled
    unique case (cur.state)
      store_route_pkg::ST_IDLE: begin
        if (sample_edge) begin
          // Not synchronised: only taken on the synchronised strobe, so it must already stand
          next_cur.reading = READING; // IEEE-754 word from the converter
          next_cur.done_n = 1'b0;
          next_cur.line_oe = cur.done_line_route; // Pull routed lines low
          next_cur.low_count = low_time(cur.timing);
          next_cur.state = store_route_pkg::ST_LOW;
        end
      end
      store_route_pkg::ST_LOW: begin
        if (cur.low_count <= 16'h0001) begin
          next_cur.done_n = 1'b1;
          next_cur.line_oe = '0; // Release to pull-up high
          next_cur.state = store_route_pkg::ST_STORE;
          ev[store_route_pkg::IRQ_DONE] = 1'b1;
        end else begin
          next_cur.low_count = cur.low_count - 16'h0001;
        end
      end
      store_route_pkg::ST_STORE: begin
        next_cur.state = store_route_pkg::ST_IDLE;
        span = {1'b0, cur.ext_store_base} + {1'b0, cur.ext_store_length};
        if (cur.ext_store_enable) begin
          if (span > store_route_pkg::REGION_TOP) begin
            ev[store_route_pkg::IRQ_BADCFG] = 1'b1; // Protect the region
          end else if (cur.store_offset + store_route_pkg::BYTES_PER_READING
                       <= cur.ext_store_length) begin
            // Next word at base plus offset, 4 bytes per reading
            next_cur.mem.valid = 1'b1;
            next_cur.mem.addr = cur.ext_store_base + cur.store_offset;
            next_cur.mem.data = cur.reading;
            next_cur.store_offset = cur.store_offset + store_route_pkg::BYTES_PER_READING;
            ev[store_route_pkg::IRQ_STORED] = 1'b1;
          end else begin
            ev[store_route_pkg::IRQ_FULL] = 1'b1; // Length reached, reading dropped
          end
        end
      end
      default: next_cur.state = store_route_pkg::ST_IDLE;
    endcase

    // Sticky status: set wins over clear
    next_cur.irq_status = (cur.irq_status & ~clr) | ev;
    next_cur.irq = |(next_cur.irq_status & next_cur.irq_enable);

    if (RESET) begin
      next_cur = '0;
      next_cur.ext_store_base = store_route_pkg::BASE_RESET;
      next_cur.ext_store_length = store_route_pkg::LENGTH_RESET;
      next_cur.done_n = 1'b1;
      next_cur.state = store_route_pkg::ST_IDLE;
    end
  end

  // ------------------------------------------------------------
  // State register and outputs
  // ------------------------------------------------------------
  // Register the whole state
  always_ff @(posedge REF_CLK) begin
    cur <= next_cur;
  end

  // Outputs straight from state flip-flops, except TRIGGER_LINE_OUT tied low
  assign PRDATA = cur.prdata;
  assign PREADY = cur.pready;
  assign PSLVERR = cur.pslverr;
  assign MEASUREMENT_DONE_OUT_N = cur.done_n; // Front output always carries done
  assign TRIGGER_LINE_OE = cur.line_oe; // Open-collector: drive only low
  assign TRIGGER_LINE_OUT = '0;
  assign MEM_WRITE = cur.mem.valid;
  assign MEM_ADDR = cur.mem.addr;
  assign MEM_DATA = cur.mem.data;
  assign IRQ = cur.irq;
endmodule : store_route

// ### tb/store_route_props.sv
// Checker: done pulse, trigger routing and storage properties of store_route
// Assumes a bind onto store_route; sees its ports and nothing else
`timescale 1ns/1ns
module store_route_props #(
  parameter int LINES = 8
) (
  input wire logic REF_CLK,
  input wire logic RESET,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [11:0] PADDR,
  input wire logic [31:0] PWDATA,
  input wire logic PREADY,
  input wire logic PSLVERR,
  input wire logic SAMPLE_TAKEN,
  input wire logic [LINES-1:0] TRIGGER_LINE_OE,
  input wire logic [LINES-1:0] TRIGGER_LINE_OUT,
  input wire logic MEASUREMENT_DONE_OUT_N,
  input wire logic MEM_WRITE,
  input wire logic [23:0] MEM_ADDR
);
  logic [23:0] base, len, off;
  logic [LINES-1:0] route;
  logic [2:0] timing;
  logic en, ok;
  logic [15:0] low_cnt, exp_cnt;
  // Accepted writes only; a refused write must not move the mirror
  assign ok = PSEL && PENABLE && PREADY && PWRITE && !PSLVERR;
  assign exp_cnt = timing[2:1] == store_route_pkg::AP_10US ? store_route_pkg::DONE_CYC_10_AZOFF
    : timing[0] ? store_route_pkg::DONE_CYC_100_AZON : store_route_pkg::DONE_CYC_100_AZOFF;
  // Settings mirror, one cycle late, which is harmless while no pulse runs
  always_ff @(posedge REF_CLK) begin
    if (RESET) begin
      base <= store_route_pkg::BASE_RESET;
      len <= store_route_pkg::LENGTH_RESET;
      off <= 24'h000000;
      route <= '0;
      timing <= 3'h0;
      en <= 1'b0;
      low_cnt <= 16'h0000;
    end else begin
      if (ok && PADDR == store_route_pkg::OFS_BASE) base <= PWDATA[23:0];
      if (ok && PADDR == store_route_pkg::OFS_LENGTH) len <= PWDATA[23:0];
      if (ok && PADDR == store_route_pkg::OFS_ROUTE) route <= PWDATA[LINES-1:0];
      if (ok && PADDR == store_route_pkg::OFS_TIMING) timing <= PWDATA[2:0];
      if (ok && PADDR == store_route_pkg::OFS_ENABLE) en <= PWDATA[0];
      if (ok && PADDR == store_route_pkg::OFS_ENABLE) off <= 24'h000000;
      else if (MEM_WRITE) off <= off + store_route_pkg::BYTES_PER_READING;
      low_cnt <= MEASUREMENT_DONE_OUT_N ? 16'h0000 : low_cnt + 16'h0001;
    end
  end
  default clocking cb @(posedge REF_CLK);
  endclocking
  default disable iff (RESET);
  sequence s_sampled;
    $rose(SAMPLE_TAKEN) && MEASUREMENT_DONE_OUT_N;
  endsequence
  sequence s_start;
    $fell(MEASUREMENT_DONE_OUT_N);
  endsequence
  sequence s_end;
    $rose(MEASUREMENT_DONE_OUT_N);
  endsequence
  AST_DONE_START: assert property (s_sampled |-> ##[2:6] !MEASUREMENT_DONE_OUT_N)
    else $error("done pulse did not follow the sample");
  AST_ROUTE_START: assert property (s_start |-> TRIGGER_LINE_OE == route)
    else $error("routed lines not sunk at pulse start");
  AST_OE_IN_PULSE: assert property (|TRIGGER_LINE_OE |-> !MEASUREMENT_DONE_OUT_N)
    else $error("trigger line sunk outside the pulse");
  AST_OUT_LOW: assert property (TRIGGER_LINE_OUT == '0)
    else $error("trigger line driven high");
  AST_LOW_TIME: assert property (s_end |-> low_cnt == exp_cnt)
    else $error("done low time wrong");
  AST_STORE_AFTER: assert property (MEM_WRITE |->
    $past(MEASUREMENT_DONE_OUT_N) && !$past(MEASUREMENT_DONE_OUT_N, 2))
    else $error("store not right after pulse end");
  AST_STORE_ADDR: assert property (MEM_WRITE |-> en && MEM_ADDR == base + off)
    else $error("store address or enable wrong");
  AST_STORE_ROOM: assert property (MEM_WRITE |-> off + 24'h000004 <= len &&
    {1'b0, base} + {1'b0, len} <= store_route_pkg::REGION_TOP)
    else $error("store beyond length or region");
endmodule : store_route_props
bind store_route store_route_props #(.LINES(LINES)) u_props (.REF_CLK(REF_CLK), .RESET(RESET),
  .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA),
  .PREADY(PREADY), .PSLVERR(PSLVERR), .SAMPLE_TAKEN(SAMPLE_TAKEN),
  .TRIGGER_LINE_OE(TRIGGER_LINE_OE), .TRIGGER_LINE_OUT(TRIGGER_LINE_OUT),
  .MEASUREMENT_DONE_OUT_N(MEASUREMENT_DONE_OUT_N), .MEM_WRITE(MEM_WRITE), .MEM_ADDR(MEM_ADDR));

// ### tb/mem_card_model.sv
// Partner model: memory card taking reading words, and pulled-up trigger lines
// Assumes one write per clock from the block, with no handshake back
`timescale 1ns/1ns
module mem_card_model (
  input wire logic clk,
  input wire logic [7:0] oe,
  input wire logic [7:0] out,
  output logic [7:0] line,
  input wire logic wr,
  input wire logic [23:0] addr,
  input wire logic [31:0] data
);
  logic [31:0] mem [logic [23:0]];
  int writes = 0;
  // Open-collector wire: the pull-up wins unless some driver sinks it
  assign line = (oe & out) | ~oe;
  // Each reading lands as one 32-bit word at its byte address
  always @(posedge clk) begin
    if (wr === 1'b1) begin
      mem[addr] = data;
      writes++;
    end
  end
endmodule : mem_card_model

// ### tb/testbench.sv
// Testbench: settings, limit queries, done pulses, routing, storage and interrupt
// Assumes store_route with a 25 MHz clock and an APB slave on its registers
`timescale 1ns/1ns
module testbench;
  logic ref_clk = 1'b0, reset = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic sample = 1'b0, pready, pslverr, done_n, mem_wr, irq, err;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, reading = 32'h0, prdata, mem_data, rd, v;
  logic [7:0] oe, tl_out, line;
  logic [23:0] mem_addr;
  logic [2:0] tset [3] = '{3'h0, 3'h2, 3'h3};
  logic [31:0] rv [3];
  int error_cnt = 0, tests_run = 0, seed = 48031, cyc = 0;
  store_route u_dut (.REF_CLK(ref_clk), .RESET(reset), .PSEL(psel), .PENABLE(penable),
    .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready),
    .PSLVERR(pslverr), .SAMPLE_TAKEN(sample), .READING(reading), .TRIGGER_LINE_IN(line),
    .TRIGGER_LINE_OE(oe), .TRIGGER_LINE_OUT(tl_out), .MEASUREMENT_DONE_OUT_N(done_n),
    .MEM_WRITE(mem_wr), .MEM_ADDR(mem_addr), .MEM_DATA(mem_data), .IRQ(irq));
  mem_card_model u_mem (.clk(ref_clk), .oe(oe), .out(tl_out), .line(line), .wr(mem_wr),
    .addr(mem_addr), .data(mem_data));
  // Free cycle count, used to time the done pulse independent of bus traffic
  always @(posedge ref_clk) begin
    cyc <= cyc + 1;
  end
  // Free-running 40 ns clock
  initial begin
    forever #20 ref_clk = ~ref_clk;
  end
  task automatic summarize();
    $display("Comparisons %0d, mismatches %0d", tests_run, error_cnt);
    if (error_cnt == 0 && tests_run > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : summarize
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      error_cnt++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  // One APB transfer; request held until pready is sampled high
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge ref_clk);
    penable <= 1'b1;
    // No cycle count assumed; only the watchdog ends a wait that never answers
    do begin
      @(posedge ref_clk);
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic e);
    apb(1'b1, a, d);
    chk({31'h0, err}, {31'h0, e});
  endtask : wr
  task automatic rdc(input logic [11:0] a, input logic [31:0] x);
    apb(1'b0, a, 32'h0);
    chk(rd, x);
  endtask : rdc
  task automatic qry(input logic [2:0] q, input logic [31:0] x);
    wr(store_route_pkg::OFS_LIMIT_QUERY, {29'h0, q}, 1'b0);
    rdc(store_route_pkg::OFS_LIMIT_DATA, x);
  endtask : qry
  function automatic logic [31:0] exp_low(input logic [2:0] t);
    int us;
    us = t[0] ? store_route_pkg::DONE_US_100_AZON : store_route_pkg::DONE_US_100_AZOFF;
    if (t[2:1] == store_route_pkg::AP_10US) us = store_route_pkg::DONE_US_10_AZOFF;
    return 32'(us * store_route_pkg::CLK_MHZ);
  endfunction : exp_low
  // One reading: count the low cycles and watch the wired trigger lines
  task automatic pulse(input logic [2:0] t, input logic [7:0] m, input logic [31:0] r);
    int n;
    int s;
    wr(store_route_pkg::OFS_TIMING, {29'h0, t}, 1'b0);
    wr(store_route_pkg::OFS_ROUTE, {24'h0, m}, 1'b0);
    @(posedge ref_clk);
    reading <= r;
    sample <= 1'b1;
    n = 0;
    do begin
      @(posedge ref_clk);
      n++;
    end while (done_n !== 1'b0 && n < 20);
    // First edge that sees done low; the free cycle count times the pulse from here
    s = cyc;
    chk({24'h0, line}, {24'h0, ~m});
    sample <= 1'b0;
    rdc(store_route_pkg::OFS_SAMPLE, {24'h0, ~m});
    while (done_n === 1'b0 && cyc - s < 20000) begin
      @(posedge ref_clk);
    end
    chk(32'(cyc - s), exp_low(t));
    chk({24'h0, line}, 32'h0000_00FF);
  endtask : pulse
  // Watchdog: the whole run needs well under 40000 cycles
  initial begin
    repeat (75000) @(posedge ref_clk);
    error_cnt++;
    summarize();
  end
  initial begin
    repeat (16) @(posedge ref_clk);
    reset <= 1'b0;
    rdc(store_route_pkg::OFS_BASE, 32'h0020_0000);
    rdc(store_route_pkg::OFS_LENGTH, 32'h0);
    rdc(store_route_pkg::OFS_ENABLE, 32'h0);
    rdc(store_route_pkg::OFS_ROUTE, 32'h0);
    qry(3'h1, 32'h0020_0000);
    qry(3'h2, 32'h00DF_FFFC);
    qry(3'h5, 32'h0);
    qry(3'h6, 32'h00C0_0000);
    wr(store_route_pkg::OFS_BASE, 32'h001F_FFFC, 1'b1);
    wr(store_route_pkg::OFS_BASE, 32'h00E0_0000, 1'b1);
    wr(store_route_pkg::OFS_LENGTH, 32'h00C0_0004, 1'b1);
    wr(store_route_pkg::OFS_BASE, 32'h00DF_FFFC, 1'b0);
    wr(store_route_pkg::OFS_LENGTH, 32'h00C0_0000, 1'b0);
    qry(3'h0, 32'h00DF_FFFC);
    qry(3'h4, 32'h00C0_0000);
    wr(12'h040, 32'h0, 1'b1);
    // Random legal base and length, read back through the present-value query; walking route bit read back directly
    for (int i = 0; i < 8; i++) begin
      v = 32'h0020_0000 + ($unsigned($random(seed)) % 32'h0030_0000) * 32'h4;
      wr(store_route_pkg::OFS_BASE, v, 1'b0);
      qry(3'h0, v);
      v = $unsigned($random(seed)) % 32'h00C0_0001;
      wr(store_route_pkg::OFS_LENGTH, v, 1'b0);
      qry(3'h4, v);
      wr(store_route_pkg::OFS_ROUTE, 32'h1 << i, 1'b0);
      rdc(store_route_pkg::OFS_ROUTE, 32'h1 << i);
    end
    // Room for two readings only, so the third is dropped
    wr(store_route_pkg::OFS_BASE, 32'h0080_0000, 1'b0);
    wr(store_route_pkg::OFS_LENGTH, 32'h0000_0008, 1'b0);
    wr(store_route_pkg::OFS_ENABLE, 32'h1, 1'b0);
    rdc(store_route_pkg::OFS_ENABLE, 32'h1);
    wr(store_route_pkg::OFS_IRQ_CLEAR, 32'hF, 1'b0);
    wr(store_route_pkg::OFS_IRQ_ENABLE, 32'h1, 1'b0);
    for (int k = 0; k < 3; k++) begin
      rv[k] = $random(seed);
      pulse(tset[k], 8'($random(seed)), rv[k]);
    end
    repeat (4) @(posedge ref_clk);
    chk(32'(u_mem.writes), 32'h2);
    chk(u_mem.mem[24'h80_0000], rv[0]);
    chk(u_mem.mem[24'h80_0004], rv[1]);
    chk({31'h0, irq}, 32'h1);
    wr(store_route_pkg::OFS_IRQ_ENABLE, 32'h0, 1'b0);
    repeat (2) @(posedge ref_clk);
    chk({31'h0, irq}, 32'h0);
    rdc(store_route_pkg::OFS_IRQ_STATUS, 32'h7);
    wr(store_route_pkg::OFS_IRQ_CLEAR, 32'hF, 1'b0);
    rdc(store_route_pkg::OFS_IRQ_STATUS, 32'h0);
    rdc(store_route_pkg::OFS_STORE_PTR, 32'h8);
    rdc(store_route_pkg::OFS_READING, rv[2]);
    // Base plus length past the region top: the pulse runs but nothing is stored
    wr(store_route_pkg::OFS_BASE, 32'h00DF_FFFC, 1'b0);
    wr(store_route_pkg::OFS_LENGTH, 32'h0000_0008, 1'b0);
    wr(store_route_pkg::OFS_ENABLE, 32'h1, 1'b0);
    pulse(3'h0, 8'h80, 32'h3F80_0000);
    repeat (4) @(posedge ref_clk);
    chk(32'(u_mem.writes), 32'h2);
    rdc(store_route_pkg::OFS_IRQ_STATUS, 32'h9);
    rdc(store_route_pkg::OFS_STORE_PTR, 32'h0);
    wr(store_route_pkg::OFS_ENABLE, 32'h0, 1'b0);
    rdc(store_route_pkg::OFS_ENABLE, 32'h0);
    summarize();
  end
endmodule : testbench
